/* File: design/cda_block_decoder.sv */
// decodes one four-unit code block per data bit from the two mark rails
`timescale 1ns/1ps
module cda_block_decoder (
    input  wire logic clock_i,
    input  wire logic srst_i,
    input  wire logic tick_i,
    input  wire logic pos_mark_i,
    input  wire logic neg_mark_i,
    output logic      bit_valid_o,
    output logic      bit_value_o,
    output logic      violation_o
);
    logic phase_reg;
    logic pol_reg;
    logic last_pol_reg;

    // two half-bit samples per block; every block opens with a mark
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            phase_reg    <= 1'b0;
            pol_reg      <= 1'b0;
            last_pol_reg <= 1'b0;
            bit_valid_o  <= 1'b0;
            bit_value_o  <= 1'b0;
            violation_o  <= 1'b0;
        end else begin
            bit_valid_o <= 1'b0;
            if (tick_i) begin
                if (!phase_reg) begin
                    // hunt for a block start: no mark means slip half a bit
                    if (pos_mark_i || neg_mark_i) begin
                        pol_reg   <= pos_mark_i;
                        phase_reg <= 1'b1;
                    end
                end else begin
                    // 1100 leaves the second half empty, 1010 marks it
                    bit_value_o  <= !(pos_mark_i || neg_mark_i);
                    // blocks alternate; an equal polarity is the octet marker
                    violation_o  <= (pol_reg == last_pol_reg);
                    last_pol_reg <= pol_reg;
                    bit_valid_o  <= 1'b1;
                    phase_reg    <= 1'b0;
                end
            end
        end
    end
endmodule

/* File: design/cda_octet_align.sv */
// receive octet alignment, blanking, alarm and slip control for the 64k line
// Summary of operation
// - missing violations: keep octet framing from the last violation seen
// - with supervision high, data stays valid without new violations
// - supervision low and violation missing: pcm output forced high
// - octet alarm rises after eight consecutive missing violations
// - blanking input high forces every output bit to one
// - line rate in, local pcm clock rate out, buffered between them
// - slow pcm clock drops an octet; fast pcm clock repeats one
// - slips act on whole octets only
// - repeat flag high while a repeated octet is being sent
// - delete flag high when a received octet is discarded
// - each line bit is four unit intervals, one code block
// - one codes as 1100, zero as 1010
// - consecutive blocks alternate polarity
// - every eighth block violates; it is the octet's last bit
// - eight bits out, one per pcm clock rise, inside the time slot
// - two octet stores alternate: one fills, the other is read
`timescale 1ns/1ps
module cda_octet_align (
    input  wire logic                 clock_i,
    input  wire logic                 srst_i,
    input  wire logic                 pos_mark_n_i,
    input  wire logic                 neg_mark_n_i,
    input  wire logic                 line_clk_i,
    input  wire logic                 local_pcm_clock_i,
    input  wire logic                 rx_timeslot_i,
    input  wire logic                 byte_lock_supervision_i,
    input  wire logic                 blanking_i,
    input  wire logic [3:0]           addr_i,
    input  wire logic [31:0]          wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic      [31:0]          rdata_o,
    output logic                      pcm_serial_out_o,
    output logic                      octet_repeat_flag_o,
    output logic                      octet_delete_flag_o,
    output logic                      octet_alarm_o,
    output logic                      irq_o
);
    import cda_pkg::*;

    logic [SYNC_W-1:0] pins_s;
    logic              line_clk_q_reg;
    logic              pcm_clk_q_reg;
    logic              line_tick;
    logic              pcm_tick;
    logic              bit_valid;
    logic              bit_value;
    logic              violation;

    logic [2:0]        bit_cnt_reg;
    logic [7:0]        shift_in_reg;
    logic              viol_seen_reg;
    logic [3:0]        miss_cnt_reg;
    logic              octet_done;
    logic              octet_missed;

    logic [7:0]        store_reg [2];
    logic [1:0]        blank_reg;
    logic              wr_sel_reg;
    logic [1:0]        fresh_reg;

    cda_out_state_t    out_state_reg;
    logic [7:0]        out_sr_reg;
    logic [2:0]        out_cnt_reg;
    logic              out_blank_reg;
    logic              burst_start;
    logic              pcm_force_one;

    logic [1:0]        ctrl_reg;
    logic [ST_W-1:0]   mask_reg;
    logic [ST_W-1:0]   status_reg;
    logic [ST_W-1:0]   status_next;
    logic [ST_W-1:0]   events;

    cda_sync #(
        .W       (SYNC_W)
    ) u_sync (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .async_i ({blanking_i, byte_lock_supervision_i, rx_timeslot_i,
                   local_pcm_clock_i, line_clk_i, neg_mark_n_i, pos_mark_n_i}),
        .sync_o  (pins_s)
    );

    // edges are taken from the synchronised copies only
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            line_clk_q_reg <= 1'b0;
            pcm_clk_q_reg  <= 1'b0;
        end else begin
            line_clk_q_reg <= pins_s[IN_LINE_CLK];
            pcm_clk_q_reg  <= pins_s[IN_PCM_CLK];
        end
    end

    assign line_tick = pins_s[IN_LINE_CLK] && !line_clk_q_reg;
    assign pcm_tick  = pins_s[IN_PCM_CLK] && !pcm_clk_q_reg;

    cda_block_decoder u_dec (
        .clock_i     (clock_i),
        .srst_i      (srst_i),
        .tick_i      (line_tick),
        .pos_mark_i  (!pins_s[IN_POS_N]),
        .neg_mark_i  (!pins_s[IN_NEG_N]),
        .bit_valid_o (bit_valid),
        .bit_value_o (bit_value),
        .violation_o (violation)
    );

    // a violation ends the octet; otherwise the counter free-runs
    assign octet_done   = bit_valid && (violation || bit_cnt_reg == 3'(OCT_BITS - 1));
    assign octet_missed = octet_done && !violation;

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            bit_cnt_reg  <= 3'h0;
            shift_in_reg <= 8'h00;
        end else if (bit_valid) begin
            shift_in_reg <= {shift_in_reg[6:0], bit_value};
            if (violation) begin
                bit_cnt_reg <= 3'h0;
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
        end
    end

    // alarm counts consecutive missing markers and clears on the next one
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            miss_cnt_reg  <= 4'h0;
            octet_alarm_o <= 1'b0;
            viol_seen_reg <= 1'b0;
        end else if (octet_done) begin
            if (violation) begin
                miss_cnt_reg  <= 4'h0;
                octet_alarm_o <= 1'b0;
                viol_seen_reg <= 1'b1;
            end else if (miss_cnt_reg != 4'(MISS_LIMIT)) begin
                miss_cnt_reg  <= miss_cnt_reg + 4'h1;
                if (miss_cnt_reg == 4'(MISS_LIMIT - 1)) begin
                    octet_alarm_o <= 1'b1;
                end
            end
        end
    end

    // ping-pong stores; the blank mark travels with each octet
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            store_reg[0] <= 8'hFF;
            store_reg[1] <= 8'hFF;
            blank_reg    <= 2'h3;
            wr_sel_reg   <= 1'b0;
        end else if (octet_done) begin
            store_reg[wr_sel_reg] <= {shift_in_reg[6:0], bit_value};
            // supervision high keeps framing from the last marker valid
            blank_reg[wr_sel_reg] <= !viol_seen_reg
                || (octet_missed && !pins_s[IN_BLS]);
            wr_sel_reg            <= !wr_sel_reg;
        end
    end

    // fresh flags an unread octet; a second one goes to the other store and is read in its place
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            fresh_reg           <= 2'h0;
            octet_delete_flag_o <= 1'b0;
        end else begin
            if (burst_start) begin
                octet_delete_flag_o <= 1'b0;
            end
            if (octet_done && fresh_reg != 2'h0 && !burst_start) begin
                octet_delete_flag_o <= 1'b1;
            end
            if (burst_start) begin
                fresh_reg <= octet_done ? 2'h1 : 2'h0;
            end else if (octet_done) begin
                fresh_reg <= 2'h1;
            end
        end
    end

    assign burst_start   = pcm_tick && pins_s[IN_TSLOT] && out_state_reg == OUT_IDLE;
    assign pcm_force_one = pins_s[IN_BLANK] || ctrl_reg[0];

    // output burst runs on the local clock, independent of the line rate
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            out_state_reg       <= OUT_IDLE;
            out_sr_reg          <= 8'hFF;
            out_cnt_reg         <= 3'h0;
            out_blank_reg       <= 1'b1;
            octet_repeat_flag_o <= 1'b0;
        end else begin
            case (out_state_reg)
                OUT_IDLE: begin
                    if (burst_start) begin
                        // most recent completed store; none new means repeat
                        out_sr_reg          <= {store_reg[!wr_sel_reg][6:0], 1'b1};
                        out_blank_reg       <= blank_reg[!wr_sel_reg];
                        out_cnt_reg         <= 3'h0;
                        octet_repeat_flag_o <= (fresh_reg == 2'h0);
                        out_state_reg       <= OUT_SHIFT;
                    end
                end
                OUT_SHIFT: begin
                    if (pcm_tick) begin
                        out_sr_reg  <= {out_sr_reg[6:0], 1'b1};
                        out_cnt_reg <= out_cnt_reg + 3'h1;
                        if (out_cnt_reg == 3'(OCT_BITS - 1)) begin
                            out_state_reg <= OUT_DONE;
                        end
                    end
                end
                OUT_DONE: begin
                    octet_repeat_flag_o <= 1'b0;
                    if (!pins_s[IN_TSLOT]) begin
                        out_state_reg <= OUT_IDLE;
                    end
                end
                default: begin
                    out_state_reg <= OUT_IDLE;
                end
            endcase
        end
    end

    // idle line is high so the slot framing never shows stray zeros
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pcm_serial_out_o <= 1'b1;
        end else if (pcm_force_one) begin
            pcm_serial_out_o <= 1'b1;
        end else if (burst_start) begin
            pcm_serial_out_o <= store_reg[!wr_sel_reg][7]
                || blank_reg[!wr_sel_reg];
        end else if (out_state_reg == OUT_SHIFT && pcm_tick) begin
            pcm_serial_out_o <= (out_cnt_reg == 3'(OCT_BITS - 1)) ? 1'b1
                : (out_sr_reg[7] || out_blank_reg);
        end
    end

    assign events[ST_REPEAT] = burst_start && fresh_reg == 2'h0;
    assign events[ST_DELETE] = octet_done && fresh_reg != 2'h0 && !burst_start;
    assign events[ST_ALARM]  = octet_missed && miss_cnt_reg == 4'(MISS_LIMIT - 1);
    assign events[ST_MISS]   = octet_missed;

    // a read clears the status, an event in the same cycle still sets
    always_comb begin
        status_next = status_reg;
        if (rd_i && addr_i == ADDR_STATUS) begin
            status_next = '0;
        end
        status_next = status_next | events;
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ctrl_reg   <= CTRL_RST;
            mask_reg   <= MASK_RST;
            status_reg <= '0;
        end else begin
            status_reg <= status_next;
            if (wr_i && addr_i == ADDR_CTRL) begin
                ctrl_reg <= wdata_i[1:0];
            end
            if (wr_i && addr_i == ADDR_MASK) begin
                mask_reg <= wdata_i[ST_W-1:0];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rdata_o <= RDATA_UNMAP;
        end else if (rd_i) begin
            case (addr_i)
                ADDR_CTRL:   rdata_o <= {30'h0000_0000, ctrl_reg};
                ADDR_MASK:   rdata_o <= {28'h000_0000, mask_reg};
                ADDR_STATUS: rdata_o <= {28'h000_0000, status_reg};
                ADDR_STATE:  rdata_o <= {22'h00_0000, out_state_reg, fresh_reg,
                                         miss_cnt_reg, wr_sel_reg, octet_alarm_o};
                default:     rdata_o <= RDATA_UNMAP;
            endcase
        end else begin
            rdata_o <= RDATA_UNMAP;
        end
    end

    assign irq_o = |(status_reg & mask_reg);

    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    sequence s_eighth_miss;
        octet_missed && miss_cnt_reg == 4'(MISS_LIMIT - 1);
    endsequence

    sequence s_burst_open;
        burst_start ##1 out_state_reg == OUT_SHIFT;
    endsequence

    property p_alarm_after_eight;
        s_eighth_miss |=> octet_alarm_o;
    endproperty
    a_alarm_after_eight: assert property (p_alarm_after_eight)
        else $error("alarm not raised after eight missing markers");

    property p_alarm_not_early;
        octet_alarm_o |-> miss_cnt_reg == 4'(MISS_LIMIT);
    endproperty
    a_alarm_not_early: assert property (p_alarm_not_early)
        else $error("alarm high before eight missing markers");

    property p_alarm_clear;
        octet_done && violation |=> !octet_alarm_o && miss_cnt_reg == 4'h0;
    endproperty
    a_alarm_clear: assert property (p_alarm_clear)
        else $error("alarm kept after marker returned");

    property p_force_one;
        pcm_force_one |=> pcm_serial_out_o;
    endproperty
    a_force_one: assert property (p_force_one)
        else $error("pcm output not forced high");

    property p_marker_aligns;
        bit_valid && violation |=> bit_cnt_reg == 3'h0;
    endproperty
    a_marker_aligns: assert property (p_marker_aligns)
        else $error("counter not realigned on marker");

    property p_keep_framing;
        bit_valid && !violation && bit_cnt_reg == 3'h7 |=> bit_cnt_reg == 3'h0;
    endproperty
    a_keep_framing: assert property (p_keep_framing)
        else $error("framing lost without marker");

    property p_repeat_flag;
        burst_start && fresh_reg == 2'h0 |=> octet_repeat_flag_o throughout
            (out_state_reg == OUT_SHIFT)[*1];
    endproperty
    a_repeat_flag: assert property (p_repeat_flag)
        else $error("repeat flag missing on repeated octet");

    property p_delete_flag;
        octet_done && fresh_reg != 2'h0 && !burst_start |=> octet_delete_flag_o;
    endproperty
    a_delete_flag: assert property (p_delete_flag)
        else $error("delete flag missing on discarded octet");

    property p_burst_len;
        s_burst_open |-> ##[1:200] out_state_reg == OUT_DONE && out_cnt_reg == 3'h0;
    endproperty
    a_burst_len: assert property (p_burst_len)
        else $error("burst did not end after eight bits");

    property p_bls_blank;
        octet_missed && !pins_s[IN_BLS] |=> blank_reg[!wr_sel_reg];
    endproperty
    a_bls_blank: assert property (p_bls_blank)
        else $error("octet not blanked without supervision");
endmodule

/* File: design/cda_pkg.sv */
// shared constants and types for the codirectional octet aligner
package cda_pkg;

    localparam int          OCT_BITS      = 8;
    localparam int          MISS_LIMIT    = 8;
    localparam int          SYNC_W        = 7;

    localparam logic [3:0]  ADDR_CTRL     = 4'h0;
    localparam logic [3:0]  ADDR_MASK     = 4'h4;
    localparam logic [3:0]  ADDR_STATUS   = 4'h8;
    localparam logic [3:0]  ADDR_STATE    = 4'hC;

    localparam int          ST_REPEAT     = 0;
    localparam int          ST_DELETE     = 1;
    localparam int          ST_ALARM      = 2;
    localparam int          ST_MISS       = 3;
    localparam int          ST_W          = 4;

    localparam logic [1:0]  CTRL_RST      = 2'h0;
    localparam logic [3:0]  MASK_RST      = 4'h0;
    localparam logic [31:0] RDATA_UNMAP   = 32'h0000_0000;

    // input bit positions in the synchroniser bundle
    localparam int          IN_POS_N      = 0;
    localparam int          IN_NEG_N      = 1;
    localparam int          IN_LINE_CLK   = 2;
    localparam int          IN_PCM_CLK    = 3;
    localparam int          IN_TSLOT      = 4;
    localparam int          IN_BLS        = 5;
    localparam int          IN_BLANK      = 6;

    typedef enum logic [1:0] {
        OUT_IDLE  = 2'b00,
        OUT_SHIFT = 2'b01,
        OUT_DONE  = 2'b11
    } cda_out_state_t;

endpackage

/* File: design/cda_sync.sv */
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module cda_sync #(
    parameter int W = 1
) (
    input  wire logic         clock_i,
    input  wire logic         srst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;

    // the first stage feeds only the second stage
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            meta_reg <= '0;
            sync_o   <= '0;
        end else begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end
endmodule

/* File: sim/cda_line_model.sv */
// line interface model: dual-rail active-low marks and the recovered line clock
`timescale 1ns/1ps
module cda_line_model #(
    parameter int HALF_CYC = 195
) (
    input  wire logic clock_i,
    output logic      pos_mark_n_o,
    output logic      neg_mark_n_o,
    output logic      line_clk_o
);
    logic pol_reg = 1'h0;

    initial begin
        pos_mark_n_o = 1'h1;
        neg_mark_n_o = 1'h1;
        line_clk_o   = 1'h0;
    end

    // one half bit; the clock rises mid-way so both rails are long settled when sampled
    task automatic send_half(input logic mark);
        @(posedge clock_i);
        pos_mark_n_o <= ~(mark & pol_reg);
        neg_mark_n_o <= ~(mark & ~pol_reg);
        repeat (HALF_CYC / 2) @(posedge clock_i);
        line_clk_o <= 1'h1;
        repeat (HALF_CYC - HALF_CYC / 2 - 1) @(posedge clock_i);
        line_clk_o <= 1'h0;
    endtask

    // earliest bit first; the clock stands still and the rails go idle between octets
    task automatic send_octet(input logic [7:0] data, input logic marker);
        for (int i = 7; i >= 0; i--) begin
            if (!(i == 0 && marker)) begin
                pol_reg = ~pol_reg;
            end
            send_half(1'h1);
            send_half(~data[i]);
        end
        @(posedge clock_i);
        pos_mark_n_o <= 1'h1;
        neg_mark_n_o <= 1'h1;
    endtask
endmodule

/* File: sim/test_cda_octet_align.sv */
// self-checking bench for the codirectional octet aligner
`timescale 1ns/1ps
module test_cda_octet_align;
    import cda_pkg::*;

    logic        clock_i = 1'h0;
    logic        srst_i  = 1'h1;
    logic        pcm_clk = 1'h0;
    logic        tslot   = 1'h0;
    logic        byte_lock_supervision     = 1'h1;
    logic        blank   = 1'h0;
    logic        wr      = 1'h0;
    logic        rd      = 1'h0;
    logic [3:0]  addr    = 4'h0;
    logic [31:0] wdata   = 32'h0000_0000;
    logic [3:0]  pcm_cnt = 4'h0;
    logic [31:0] rdata;
    logic        pos_n, neg_n, line_clk, pcm_out, rep_flag, del_flag, alarm, irq;
    int          cycles      = 0;
    int          miscompares = 0;
    int          checked     = 0;

    cda_line_model #(.HALF_CYC(195)) i_line (
        .clock_i(clock_i), .pos_mark_n_o(pos_n), .neg_mark_n_o(neg_n), .line_clk_o(line_clk));

    cda_octet_align i_dut (
        .clock_i(clock_i), .srst_i(srst_i), .pos_mark_n_i(pos_n), .neg_mark_n_i(neg_n),
        .line_clk_i(line_clk), .local_pcm_clock_i(pcm_clk), .rx_timeslot_i(tslot),
        .byte_lock_supervision_i(byte_lock_supervision), .blanking_i(blank), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pcm_serial_out_o(pcm_out),
        .octet_repeat_flag_o(rep_flag), .octet_delete_flag_o(del_flag),
        .octet_alarm_o(alarm), .irq_o(irq));

    always #20 clock_i = ~clock_i;

    // pcm clock of 12 cycles, the nearest whole count to 2.048 MHz
    always @(posedge clock_i) begin
        pcm_cnt <= (pcm_cnt == 4'hB) ? 4'h0 : pcm_cnt + 4'h1;
        pcm_clk <= (pcm_cnt == 4'hB) || (pcm_cnt < 4'h5);
        cycles  <= cycles + 1;
        if (cycles == 80000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_word({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge clock_i);
        wr    <= 1'h0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock_i);
        addr <= a;
        rd   <= 1'h1;
        @(posedge clock_i);
        rd   <= 1'h0;
        #1 d = rdata;
    endtask

    // one time slot of eight pcm clock rises; each bit sampled well inside its period
    task automatic burst(input logic [7:0] exp, input logic exp_rep);
        logic [7:0] oct;
        logic       rep;
        do @(posedge clock_i); while (pcm_cnt != 4'hB);
        tslot <= 1'h1;
        for (int k = 7; k >= 0; k--) begin
            repeat (9) @(posedge clock_i);
            #1 oct[k] = pcm_out;
            if (k == 0) rep = rep_flag;
            repeat (3) @(posedge clock_i);
        end
        tslot <= 1'h0;
        repeat (9) @(posedge clock_i);
        #1 check_bit(pcm_out, 1'h1);
        check_word({24'h00_0000, oct}, {24'h00_0000, exp});
        check_bit(rep, exp_rep);
    endtask

    task automatic t_reset();
        logic [31:0] d;
        check_bit(pcm_out, 1'h1);
        check_bit(irq, 1'h0);
        reg_read(ADDR_CTRL, d);
        check_word(d, {30'h0000_0000, CTRL_RST});
        reg_read(ADDR_MASK, d);
        check_word(d, {28'h000_0000, MASK_RST});
        reg_write(4'h1, 32'hFFFF_FFFF);
        reg_read(4'h1, d);
        check_word(d, RDATA_UNMAP);
    endtask

    task automatic t_deliver_repeat();
        logic [31:0] d;
        i_line.send_octet(8'hFF, 1'h1);
        i_line.send_octet(8'hA5, 1'h1);
        burst(8'hA5, 1'h0);
        reg_read(ADDR_STATUS, d);
        check_word(d, 32'h0000_0002);
        reg_write(ADDR_MASK, 32'h0000_0001);
        burst(8'hA5, 1'h1);
        #1 check_bit(irq, 1'h1);
        reg_read(ADDR_STATUS, d);
        check_word(d, 32'h0000_0001);
        check_bit(irq, 1'h0);
    endtask

    task automatic t_delete();
        i_line.send_octet(8'h3C, 1'h1);
        i_line.send_octet(8'hC3, 1'h1);
        check_bit(del_flag, 1'h1);
        check_bit(irq, 1'h0);
        burst(8'hC3, 1'h0);
        check_bit(del_flag, 1'h0);
    endtask

    task automatic t_supervise();
        i_line.send_octet(8'h5A, 1'h0);
        burst(8'h5A, 1'h0);
        @(posedge clock_i);
        byte_lock_supervision <= 1'h0;
        i_line.send_octet(8'h0F, 1'h0);
        burst(8'hFF, 1'h0);
        @(posedge clock_i);
        byte_lock_supervision <= 1'h1;
    endtask

    task automatic t_alarm();
        logic [31:0] d;
        i_line.send_octet(8'h81, 1'h1);
        for (int k = 1; k <= 8; k++) begin
            i_line.send_octet(8'h00, 1'h0);
            check_bit(alarm, k == 8);
        end
        reg_read(ADDR_STATUS, d);
        check_word(d, 32'h0000_000E);
        i_line.send_octet(8'h7E, 1'h1);
        check_bit(alarm, 1'h0);
        burst(8'h7E, 1'h0);
    endtask

    task automatic t_blank();
        logic [31:0] d;
        @(posedge clock_i);
        blank <= 1'h1;
        burst(8'hFF, 1'h1);
        @(posedge clock_i);
        blank <= 1'h0;
        reg_write(ADDR_CTRL, 32'h0000_0001);
        reg_read(ADDR_CTRL, d);
        check_word(d, 32'h0000_0001);
        burst(8'hFF, 1'h1);
        reg_write(ADDR_CTRL, 32'h0000_0000);
        burst(8'h7E, 1'h1);
    endtask

    initial begin
        repeat (5) @(posedge clock_i);
        srst_i <= 1'h0;
        repeat (3) @(posedge clock_i);
        t_reset();
        t_deliver_repeat();
        t_delete();
        t_supervise();
        t_alarm();
        t_blank();
        conclude();
    end
endmodule
